// *** logic/lbss_map.svh ***
/*
  Offsets, field positions, masks and reset values of the legacy BIOS
  segment steering block. Assumes an 8-bit configuration address space.
*/
`ifndef LBSS_MAP_SVH
`define LBSS_MAP_SVH

// ****************************************************************
// register offsets in configuration space
// ****************************************************************
`define LBSS_OFF_C0_C7 8'h91
`define LBSS_OFF_C8_CF 8'h92
`define LBSS_OFF_D0_D7 8'h93

// ****************************************************************
// field layout and reset
// ****************************************************************
`define LBSS_LO_LSB 0
`define LBSS_HI_LSB 4
`define LBSS_WR_MASK 8'h33
`define LBSS_RST_VAL 8'h00

// ****************************************************************
// segment numbering: address bits 19:14, 16 KB each
// ****************************************************************
`define LBSS_SEG_FIRST 6'h30
`define LBSS_SEG_LAST 6'h35

`endif

// *** logic/lbss_pkg.sv ***
/*
  Types of the legacy BIOS segment steering block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package lbss_pkg;

  // steering code held in each attribute field
  typedef enum logic [1:0] {
    LBSS_ATTR_LINK_ONLY = 2'b00,
    LBSS_ATTR_READ_ONLY = 2'b01,
    LBSS_ATTR_WRITE_ONLY = 2'b10,
    LBSS_ATTR_NORMAL = 2'b11
  } lbss_attr_e;

  typedef logic [7:0] lbss_reg_t;

endpackage : lbss_pkg
`default_nettype wire

// *** logic/lbss_seg_decode.sv ***
/*
  Combinational segment decode: picks the attribute field that covers a
  host address. Assumes a 20-bit legacy address below 1 MB.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lbss_map.svh"

module lbss_seg_decode (
  // host address
  input wire logic [19:0] host_addr,
  // stored attribute registers
  input wire lbss_pkg::lbss_reg_t attr_c0_c7,
  input wire lbss_pkg::lbss_reg_t attr_c8_cf,
  input wire lbss_pkg::lbss_reg_t attr_d0_d7,
  // decode result
  output logic seg_hit,
  output logic [2:0] seg_num,
  output lbss_pkg::lbss_attr_e seg_attr
);

  logic [5:0] seg_idx;
  logic [5:0] seg_off;
  lbss_pkg::lbss_reg_t sel_reg;

  always_comb begin
    seg_idx = host_addr[19:14];
    seg_off = seg_idx - `LBSS_SEG_FIRST;
    seg_hit = (seg_idx >= `LBSS_SEG_FIRST) && (seg_idx <= `LBSS_SEG_LAST);
    seg_num = seg_off[2:0];
    case (seg_off[2:1])
      2'b00: sel_reg = attr_c0_c7;
      2'b01: sel_reg = attr_c8_cf;
      2'b10: sel_reg = attr_d0_d7;
      default: sel_reg = `LBSS_RST_VAL;
    endcase
    // odd segment takes the upper field
    if (seg_off[0]) begin
      seg_attr = lbss_pkg::lbss_attr_e'(sel_reg[`LBSS_HI_LSB +: 2]);
    end else begin
      seg_attr = lbss_pkg::lbss_attr_e'(sel_reg[`LBSS_LO_LSB +: 2]);
    end
  end

endmodule : lbss_seg_decode
`default_nettype wire

// *** logic/lbss_top.sv ***
/*
  Legacy BIOS shadow segment steering: three attribute registers in
  configuration space and the read/write routing of six 16 KB segments.
  Assumes config cycles and host cycles arrive as one-cycle strobes on clk,
  and the lock level comes from logic on the same clock.
*/
// What this block does
// - segment 0C0000-0C3FFF steered by low field of register 91h.
// - segment 0C4000-0C7FFF steered by high field of register 91h.
// - segment 0C8000-0CBFFF steered by low field of register 92h.
// - register 92h high field steers segment up to 0CFFFF, same codes.
// - segment 0D0000-0D3FFF steered by low field of register 93h.
// - segment 0D4000-0D7FFF steered by high field of register 93h.
// - code 00 sends all reads and writes to the link, never DRAM.
// - code 01 reads from DRAM, writes go to the link.
// - code 10 writes to DRAM, reads go to the link.
// - code 11 reads and writes both go to DRAM.
// - while lock mode is active, attribute writes are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "lbss_map.svh"

module lbss_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // lock level
  input wire logic trusted_execution_lock_mode,
  // host access
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [19:0] host_addr,
  // routing decision
  output logic route_valid,
  output logic route_hit,
  output logic route_dram,
  output logic route_south_bridge_link
);

  // ****************************************************************
  // attribute registers
  // ****************************************************************
  lbss_pkg::lbss_reg_t attr_c0_c7_q;
  lbss_pkg::lbss_reg_t attr_c8_cf_q;
  lbss_pkg::lbss_reg_t attr_d0_d7_q;
  logic wr_ok;

  // locked writes are dropped silently, no error is reported
  assign wr_ok = cfg_wr && !trusted_execution_lock_mode;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      attr_c0_c7_q <= `LBSS_RST_VAL;
    end else if (wr_ok && cfg_addr == `LBSS_OFF_C0_C7) begin
      attr_c0_c7_q <= cfg_wdata & `LBSS_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      attr_c8_cf_q <= `LBSS_RST_VAL;
    end else if (wr_ok && cfg_addr == `LBSS_OFF_C8_CF) begin
      // upper field stays writable although marked reserved
      attr_c8_cf_q <= cfg_wdata & `LBSS_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      attr_d0_d7_q <= `LBSS_RST_VAL;
    end else if (wr_ok && cfg_addr == `LBSS_OFF_D0_D7) begin
      attr_d0_d7_q <= cfg_wdata & `LBSS_WR_MASK;
    end
  end

  // ****************************************************************
  // configuration read
  // ****************************************************************
  logic [7:0] cfg_rdata_q;
  logic cfg_rvalid_q;

  // offsets outside this block read as zero here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_rdata_q <= 8'h00;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        case (cfg_addr)
          `LBSS_OFF_C0_C7: cfg_rdata_q <= attr_c0_c7_q;
          `LBSS_OFF_C8_CF: cfg_rdata_q <= attr_c8_cf_q;
          `LBSS_OFF_D0_D7: cfg_rdata_q <= attr_d0_d7_q;
          default: cfg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign cfg_rdata = cfg_rdata_q;
  assign cfg_rvalid = cfg_rvalid_q;

  // ****************************************************************
  // host steering
  // ****************************************************************
  logic seg_hit;
  logic [2:0] seg_num;
  lbss_pkg::lbss_attr_e seg_attr;

  lbss_seg_decode u_decode (
    .host_addr(host_addr),
    .attr_c0_c7(attr_c0_c7_q),
    .attr_c8_cf(attr_c8_cf_q),
    .attr_d0_d7(attr_d0_d7_q),
    .seg_hit(seg_hit),
    .seg_num(seg_num),
    .seg_attr(seg_attr)
  );

  // bit 0 of the code enables reads to DRAM, bit 1 writes
  function automatic logic lbss_to_dram(input lbss_pkg::lbss_attr_e attr,
                                         input logic we);
    case (attr)
      lbss_pkg::LBSS_ATTR_LINK_ONLY: lbss_to_dram = 1'b0;
      lbss_pkg::LBSS_ATTR_READ_ONLY: lbss_to_dram = !we;
      lbss_pkg::LBSS_ATTR_WRITE_ONLY: lbss_to_dram = we;
      lbss_pkg::LBSS_ATTR_NORMAL: lbss_to_dram = 1'b1;
      default: lbss_to_dram = 1'b0;
    endcase
  endfunction : lbss_to_dram

  logic route_valid_q;
  logic route_hit_q;
  logic route_dram_q;
  logic route_link_q;

  // one cycle from request to decision; addresses outside the six
  // segments leave both routes low for the rest of the decoder
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      route_valid_q <= 1'b0;
      route_hit_q <= 1'b0;
      route_dram_q <= 1'b0;
      route_link_q <= 1'b0;
    end else begin
      route_valid_q <= host_req;
      route_hit_q <= host_req && seg_hit;
      route_dram_q <= host_req && seg_hit
                      && lbss_to_dram(seg_attr, host_we);
      route_link_q <= host_req && seg_hit
                      && !lbss_to_dram(seg_attr, host_we);
    end
  end

  assign route_valid = route_valid_q;
  assign route_hit = route_hit_q;
  assign route_dram = route_dram_q;
  assign route_south_bridge_link = route_link_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_lock_blocks_write: assert property (
    trusted_execution_lock_mode && cfg_wr |=>
      $stable(attr_c0_c7_q) && $stable(attr_c8_cf_q)
      && $stable(attr_d0_d7_q))
    else $error("attribute changed while locked");

  a_write_stores_c8: assert property (
    !trusted_execution_lock_mode && cfg_wr
      && cfg_addr == `LBSS_OFF_C8_CF |=>
      attr_c8_cf_q == ($past(cfg_wdata) & `LBSS_WR_MASK))
    else $error("write to 92h not stored");

  a_reserved_zero: assert property (
    ((attr_c0_c7_q | attr_c8_cf_q | attr_d0_d7_q)
      & ~`LBSS_WR_MASK) == 8'h00)
    else $error("reserved attribute bit set");

  a_readback_d0: assert property (
    cfg_rd && cfg_addr == `LBSS_OFF_D0_D7 |=>
      cfg_rvalid && cfg_rdata == $past(attr_d0_d7_q))
    else $error("readback of 93h wrong");

  a_code00_link: assert property (
    host_req && seg_hit && seg_attr == lbss_pkg::LBSS_ATTR_LINK_ONLY |=>
      route_south_bridge_link && !route_dram)
    else $error("code 00 access reached DRAM");

  a_code01_split: assert property (
    host_req && seg_hit && seg_attr == lbss_pkg::LBSS_ATTR_READ_ONLY |=>
      route_dram == !$past(host_we)
      && route_south_bridge_link == $past(host_we))
    else $error("code 01 routing wrong");

  a_code10_split: assert property (
    host_req && seg_hit && seg_attr == lbss_pkg::LBSS_ATTR_WRITE_ONLY |=>
      route_dram == $past(host_we)
      && route_south_bridge_link == !$past(host_we))
    else $error("code 10 routing wrong");

  a_code11_dram: assert property (
    host_req && seg_hit && seg_attr == lbss_pkg::LBSS_ATTR_NORMAL |=>
      route_dram && !route_south_bridge_link)
    else $error("code 11 access left DRAM");

  a_seg_c0_low: assert property (
    host_req && host_addr[19:14] == 6'h30 |=>
      route_hit && route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_c0_c7_q[1:0])), $past(host_we)))
    else $error("segment 0C0000 not steered by 91h low field");

  a_seg_c4_high: assert property (
    host_req && host_addr[19:14] == 6'h31 |=>
      route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_c0_c7_q[5:4])), $past(host_we)))
    else $error("segment 0C4000 not steered by 91h high field");

  a_seg_c8_low: assert property (
    host_req && host_addr[19:14] == 6'h32 |=>
      route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_c8_cf_q[1:0])), $past(host_we)))
    else $error("segment 0C8000 not steered by 92h low field");

  a_seg_cc_high: assert property (
    host_req && host_addr[19:14] == 6'h33 |=>
      route_hit && route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_c8_cf_q[5:4])), $past(host_we)))
    else $error("segment 0CC000 not steered by 92h high field");

  a_seg_number: assert property (
    host_req && host_addr[19:14] == 6'h33 |-> seg_hit && seg_num == 3'h3)
    else $error("segment 0CC000 decoded to wrong field");

  a_seg_d0_low: assert property (
    host_req && host_addr[19:14] == 6'h34 |=>
      route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_d0_d7_q[1:0])), $past(host_we)))
    else $error("segment 0D0000 not steered by 93h low field");

  a_seg_d4_high: assert property (
    host_req && host_addr[19:14] == 6'h35 |=>
      route_dram == lbss_to_dram(
        lbss_pkg::lbss_attr_e'($past(attr_d0_d7_q[5:4])), $past(host_we)))
    else $error("segment 0D4000 not steered by 93h high field");

  a_miss_no_route: assert property (
    host_req && !seg_hit |=> !route_hit && !route_dram
      && !route_south_bridge_link)
    else $error("out of range access routed");

  c_locked_write: cover property (trusted_execution_lock_mode && cfg_wr);
  c_read_only_write: cover property (
    host_req && host_we && seg_attr == lbss_pkg::LBSS_ATTR_READ_ONLY);
  c_write_then_use: cover property (
    wr_ok && cfg_addr == `LBSS_OFF_C0_C7 ##1 host_req && seg_hit);

endmodule : lbss_top
`default_nettype wire

// *** tb/lbss_host_model.sv ***
/*
  Host-side partner: issues host cycles to the steering block and returns
  the routing decision. Assumes the block answers one cycle after a strobe.
*/
`timescale 1ns/1ns
`default_nettype none

module lbss_host_model (
  // clock
  input wire logic clk,
  // host access
  output logic host_req,
  output logic host_we,
  output logic [19:0] host_addr,
  // routing decision
  input wire logic route_valid,
  input wire logic route_hit,
  input wire logic route_dram,
  input wire logic route_south_bridge_link
);
  initial begin
    host_req = 1'b0;
    host_we = 1'b0;
    host_addr = 20'h00000;
  end

  // ****************************************************************
  // one host cycle; result packs valid, hit, dram, link
  // ****************************************************************
  task automatic access(input logic we, input logic [19:0] addr,
                        output logic [3:0] res);
    @(posedge clk);
    #2;
    host_req = 1'b1;
    host_we = we;
    host_addr = addr;
    @(posedge clk);
    #2;
    res = {route_valid, route_hit, route_dram, route_south_bridge_link};
    host_req = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    host_we = ~we;
    host_addr = ~addr;
  endtask : access
endmodule : lbss_host_model
`default_nettype wire

// *** tb/tb.sv ***
/*
  Self-checking bench for the segment steering block: config reads and
  writes, host routing per segment and code, lock. Assumes lbss_top.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lbss_map.svh"

module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic lock_mode = 1'b0;
  logic host_req;
  logic host_we;
  logic [19:0] host_addr;
  logic route_valid;
  logic route_hit;
  logic route_dram;
  logic route_link;
  int fail_count = 0;
  int checks = 0;
  // reserved bits set on purpose in most patterns
  logic [7:0] pat [0:4][0:2] = '{'{8'h00, 8'h00, 8'h00},
    '{8'hD5, 8'h55, 8'h5D}, '{8'hAA, 8'hEE, 8'hAA},
    '{8'hFF, 8'hFF, 8'hFF}, '{8'h12, 8'h30, 8'h21}};

  always #20 clk = ~clk;

  lbss_top u_lbss_top (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .trusted_execution_lock_mode(lock_mode), .host_req(host_req),
    .host_we(host_we), .host_addr(host_addr), .route_valid(route_valid),
    .route_hit(route_hit), .route_dram(route_dram),
    .route_south_bridge_link(route_link));

  lbss_host_model u_lbss_host_model (.clk(clk), .host_req(host_req),
    .host_we(host_we), .host_addr(host_addr), .route_valid(route_valid),
    .route_hit(route_hit), .route_dram(route_dram),
    .route_south_bridge_link(route_link));

  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #2;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask : cfg_write

  // result packs rvalid above rdata, sampled in the answer cycle
  task automatic cfg_read(input logic [7:0] a, output logic [8:0] res);
    @(posedge clk);
    #2;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #2;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    res = {cfg_rvalid, cfg_rdata};
  endtask : cfg_read

  task automatic cmp_cfg(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_cfg

  task automatic cmp_route(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_route

  // low code bit enables DRAM reads, high bit DRAM writes
  function automatic logic [3:0] exp_route(input logic we,
                                           input logic [1:0] c);
    logic dram;
    dram = we ? c[1] : c[0];
    return {2'b11, dram, ~dram};
  endfunction : exp_route

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [8:0] rv;
    logic [3:0] rr;
    logic [7:0] r;
    logic [1:0] c;
    logic [19:0] a;
    repeat (12) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      cfg_read(`LBSS_OFF_C0_C7 + 8'(k), rv);
      cmp_cfg(rv, 9'h100);
    end
    u_lbss_host_model.access(1'b1, 20'hD7FFF, rr);
    cmp_route(rr, 4'b1101);
    $display("test reset done");
    for (int p = 0; p < 5; p++) begin
      for (int k = 0; k < 3; k++) begin
        cfg_write(`LBSS_OFF_C0_C7 + 8'(k), pat[p][k]);
        cfg_read(`LBSS_OFF_C0_C7 + 8'(k), rv);
        cmp_cfg(rv, {1'b1, pat[p][k] & 8'h33});
      end
      for (int s = 0; s < 6; s++) begin
        r = pat[p][s / 2] & 8'h33;
        c = s[0] ? r[5:4] : r[1:0];
        // even segments at their first byte, odd ones at their last
        a = 20'hC0000 + 20'(s) * 20'h04000 + (s[0] ? 20'h03FFF : 20'h0);
        for (int w = 0; w < 2; w++) begin
          u_lbss_host_model.access(w[0], a, rr);
          cmp_route(rr, exp_route(w[0], c));
        end
      end
      u_lbss_host_model.access(1'b0, 20'hBFFFF, rr);
      cmp_route(rr, 4'b1000);
      u_lbss_host_model.access(1'b1, 20'hD8000, rr);
      cmp_route(rr, 4'b1000);
    end
    $display("test segments and codes done");
    lock_mode = 1'b1;
    cfg_write(`LBSS_OFF_C0_C7, 8'hFF);
    cfg_write(`LBSS_OFF_D0_D7, 8'h00);
    cfg_read(`LBSS_OFF_C0_C7, rv);
    cmp_cfg(rv, 9'h112);
    cfg_read(`LBSS_OFF_D0_D7, rv);
    cmp_cfg(rv, 9'h121);
    u_lbss_host_model.access(1'b0, 20'hC0000, rr);
    cmp_route(rr, 4'b1101);
    lock_mode = 1'b0;
    cfg_write(`LBSS_OFF_C0_C7, 8'hFF);
    cfg_read(`LBSS_OFF_C0_C7, rv);
    cmp_cfg(rv, 9'h133);
    $display("test lock done");
    cfg_write(8'h90, 8'hFF);
    cfg_write(8'h94, 8'hFF);
    cfg_read(8'h90, rv);
    cmp_cfg(rv, 9'h100);
    cfg_read(8'h94, rv);
    cmp_cfg(rv, 9'h100);
    $display("test unmapped done");
    // host cycle taken the edge after the write must see the new code
    fork
      cfg_write(`LBSS_OFF_C0_C7, 8'h01);
      begin
        @(posedge clk);
        u_lbss_host_model.access(1'b1, 20'hC0000, rr);
      end
    join
    cmp_route(rr, 4'b1101);
    cfg_read(`LBSS_OFF_C0_C7, rv);
    cmp_cfg(rv, 9'h101);
    $display("test write then use done");
    @(posedge clk);
    #2;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      cfg_read(`LBSS_OFF_C0_C7 + 8'(k), rv);
      cmp_cfg(rv, 9'h100);
    end
    u_lbss_host_model.access(1'b0, 20'hCC000, rr);
    cmp_route(rr, 4'b1101);
    $display("test mid-run reset done");
    finish_test();
  end

  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
